// file: core/hpds_host_seq.sv
// Local design decisions: the APB interface to the registers and the address map.
module hpds_host_seq
   import hpds_pkg::*;
#(
   parameter int unsigned RETRY_LIMIT = RETRY_CYCLES
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Configuration channel supply
   output logic             cfg_supply_en,
   // Identification data probe engine
   output logic             probe_req,
   output logic      [7:0]  probe_addr,
   input  wire logic        probe_done,
   input  wire logic        probe_found,
   input  wire logic        probe_digital,
   input  wire logic        probe_link,
   // Colour output load check
   output logic             load_req,
   input  wire logic        load_done,
   input  wire logic        load_found,
   // Monitor-ready comparator (asynchronous)
   input  wire logic        rdy_pin,
   // Differential video transmitter
   output logic             tx_en
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   typedef enum logic [3:0] {
      ST_OFF, ST_PRI_REQ, ST_PRI_WAIT, ST_ALT_REQ, ST_ALT_WAIT,
      ST_LOAD_REQ, ST_LOAD_WAIT, ST_RDY_WAIT, ST_RUN, ST_UNPLUG
   } hpds_state_t;

   hpds_state_t        st_q;       // Sequencer state
   hpds_state_t        st_d;       // Next state
   logic [TMR_W-1:0]   tmr_q;      // Retry window counter
   logic               tmr_out;    // Retry window used up
   hpds_cap_t          cap_q;      // Capability found or assumed
   logic               dig_q;      // Digital monitor flag seen
   logic               link_q;     // Data asks for the video link
   logic               tx_q;       // Transmitter enable
   logic               preq_q;     // Probe request pulse
   logic [7:0]         paddr_q;    // Probe address
   logic               lreq_q;     // Load check request pulse
   logic [0:0]         ctrl_q;     // Control register
   logic [INT_W-1:0]   ist_q;      // Sticky interrupt status
   logic [INT_W-1:0]   ien_q;      // Interrupt enables
   logic [INT_W-1:0]   evt;        // Events this cycle
   logic [INT_W-1:0]   clr;        // Clear strobe from software
   logic [31:0]        rdata_q;    // Read data register
   logic               mapped;     // Address decodes
   logic               wr_acc;     // Write access phase
   logic               run_en;     // Software allows the sequence

   hpds_sync_if rdy_ln ();

   ////////////////////////////////////////////////////////////////////
   // Ready-line synchroniser

   assign rdy_ln.raw = rdy_pin;

   // Threshold decision enters through three flops
   hpds_sync u_rdy_sync (
      .mclk (mclk),
      .nrst (nrst),
      .ln   (rdy_ln)
   );

   assign run_en = ctrl_q[CTRL_RUN_BIT];

   ////////////////////////////////////////////////////////////////////
   // Retry window counter, cleared whenever probing restarts

   assign tmr_out = (tmr_q >= TMR_W'(RETRY_LIMIT));

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tmr_q <= '0;
      end else if (st_q == ST_OFF || st_q == ST_UNPLUG) begin
         tmr_q <= '0;
      end else if (!tmr_out) begin
         // Counted on the known reference clock
         tmr_q <= tmr_q + TMR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_OFF: begin
            // Supply goes on as the sequence leaves this state
            if (run_en) st_d = ST_PRI_REQ;
         end
         ST_PRI_REQ: begin
            st_d = ST_PRI_WAIT;
         end
         ST_PRI_WAIT: begin
            if (probe_done && probe_found) begin
               // Digital monitor must show ready first
               st_d = probe_digital ? ST_RDY_WAIT : ST_RUN;
            end else if (probe_done) begin
               // Retry until the window closes
               st_d = tmr_out ? ST_ALT_REQ : ST_PRI_REQ;
            end
         end
         ST_ALT_REQ: begin
            st_d = ST_ALT_WAIT;
         end
         ST_ALT_WAIT: begin
            // Fall back to the load
            if (probe_done) st_d = probe_found ? ST_RUN : ST_LOAD_REQ;
         end
         ST_LOAD_REQ: begin
            st_d = ST_LOAD_WAIT;
         end
         ST_LOAD_WAIT: begin
            if (load_done) st_d = ST_RUN;
         end
         ST_RDY_WAIT: begin
            if (rdy_ln.lvl) st_d = ST_RUN;
         end
         ST_RUN: begin
            // Loss of the ready line means unplug for a digital monitor
            if (dig_q && !rdy_ln.lvl) st_d = ST_UNPLUG;
         end
         ST_UNPLUG: begin
            // Recovery restarts probing for the new monitor
            if (rdy_ln.lvl) st_d = ST_PRI_REQ;
         end
         default: st_d = ST_OFF;
      endcase
      // Software can stop the sequence at any time
      if (!run_en) st_d = ST_OFF;
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!nrst) st_q <= ST_OFF;
      else       st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////
   // Probe and load-check requests

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         preq_q  <= 1'b0;
         paddr_q <= ADDR_PRI;
         lreq_q  <= 1'b0;
      end else begin
         preq_q <= (st_d == ST_PRI_REQ) || (st_d == ST_ALT_REQ);
         lreq_q <= (st_d == ST_LOAD_REQ);
         if (st_d == ST_PRI_REQ) begin
            paddr_q <= ADDR_PRI;
         end else if (st_d == ST_ALT_REQ) begin
            paddr_q <= ADDR_ALT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capability and link request bookkeeping

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cap_q  <= CAP_NONE;
         dig_q  <= 1'b0;
         link_q <= 1'b0;
      end else if (st_q == ST_OFF) begin
         cap_q  <= CAP_NONE;
         dig_q  <= 1'b0;
         link_q <= 1'b0;
      end else if (probe_done && probe_found && st_q == ST_PRI_WAIT) begin
         cap_q  <= probe_digital ? CAP_DIGITAL : CAP_ANALOGUE;
         dig_q  <= probe_digital;
         link_q <= probe_link;
      end else if (probe_done && st_q == ST_ALT_WAIT) begin
         // Alternate data is decoded by software for its modes
         cap_q  <= probe_found ? CAP_ALT_DATA : CAP_NONE;
         dig_q  <= 1'b0;
         link_q <= probe_found && probe_link;
      end else if (load_done && st_q == ST_LOAD_WAIT) begin
         // A loaded output means a basic VGA monitor
         cap_q  <= load_found ? CAP_VGA : CAP_NONE;
         link_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmitter enable

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_q <= 1'b0;
      end else begin
         // One cycle into service, so link_q is the new data's
         // Dropped the cycle after a digital monitor loses the ready line
         tx_q <= (st_q == ST_RUN) && (st_d == ST_RUN) && link_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt events; set wins over a clear in the same cycle

   always_comb begin
      evt = '0;
      // Reattach tells software to reread the data
      evt[EVT_REATTACH]  = (st_q == ST_UNPLUG) && rdy_ln.rise;
      evt[EVT_UNPLUG]    = (st_q == ST_RUN) && (st_d == ST_UNPLUG);
      evt[EVT_DETECTED]  = (st_q != ST_RUN) && (st_d == ST_RUN);
      evt[EVT_RETRY_OUT] = (st_q == ST_PRI_WAIT)
                           && (st_d == ST_ALT_REQ);
   end

   assign wr_acc = psel && penable && pwrite;
   assign clr    = (wr_acc && paddr == OFS_INT_CLR)
                   ? pwdata[INT_W-1:0] : '0;

   // Sticky status
   always_ff @(posedge mclk) begin
      if (!nrst) ist_q <= INT_RST;
      else       ist_q <= (ist_q & ~clr) | evt;
   end

   // Level interrupt from any enabled status bit
   assign irq = |(ist_q & ien_q);

   ////////////////////////////////////////////////////////////////////
   // APB register writes

   assign mapped = (paddr == OFS_CTRL)   || (paddr == OFS_STATUS)
                || (paddr == OFS_INT_ST) || (paddr == OFS_INT_EN)
                || (paddr == OFS_INT_CLR);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
         ien_q  <= INT_RST;
      end else if (wr_acc) begin
         if (paddr == OFS_CTRL)   ctrl_q <= pwdata[0:0];
         if (paddr == OFS_INT_EN) ien_q  <= pwdata[INT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB read data, captured in the setup cycle

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         rdata_q <= 32'h0000_0000;
         unique case (paddr)
            OFS_CTRL:   rdata_q[0:0] <= ctrl_q;
            OFS_STATUS: begin
               // Capability and transmitter state
               rdata_q[STAT_CAP_LSB +: 3] <= cap_q;
               rdata_q[STAT_TX_BIT]       <= tx_q;
               rdata_q[STAT_RDY_BIT]      <= rdy_ln.lvl;
               rdata_q[STAT_DIG_BIT]      <= dig_q;
            end
            OFS_INT_ST: rdata_q[INT_W-1:0] <= ist_q;
            OFS_INT_EN: rdata_q[INT_W-1:0] <= ien_q;
            default:    rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = rdata_q;

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign cfg_supply_en = (st_q != ST_OFF);
   assign probe_req     = preq_q;
   assign probe_addr    = paddr_q;
   assign load_req      = lreq_q;
   assign tx_en         = tx_q;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_pri_miss;
      (st_q == ST_PRI_WAIT) && probe_done && !probe_found;
   endsequence

   sequence s_alt_miss;
      (st_q == ST_ALT_WAIT) && probe_done && !probe_found && run_en;
   endsequence

   // Alternate probe is issued only after the retry window has closed
   chk_alt_after_win: assert property (
      probe_req && probe_addr == ADDR_ALT |-> tmr_out)
      else $error("alternate probe before retry window closed");

   // A miss inside the window retries the primary address
   chk_pri_retry: assert property (
      s_pri_miss ##0 !tmr_out ##0 run_en
      |=> probe_req && probe_addr == ADDR_PRI)
      else $error("primary probe not retried");

   // Alternate miss leads to a load check at the next edge
   chk_load_fallback: assert property (
      s_alt_miss |=> load_req)
      else $error("load check not issued after alternate miss");

   // Load found gives basic VGA capability
   chk_vga_assumed: assert property (
      (st_q == ST_LOAD_WAIT) && load_done && load_found && run_en
      |=> cap_q == CAP_VGA)
      else $error("VGA capability not assumed");

   // Digital monitor never enables before ready is high
   chk_wait_ready: assert property (
      (st_q == ST_RDY_WAIT) && !rdy_ln.lvl |=> !tx_en)
      else $error("transmitter enabled before monitor ready");

   // Transmitter follows the data's link request
   chk_tx_gate: assert property (
      tx_en |-> link_q && cap_q != CAP_NONE)
      else $error("transmitter on without a link request");

   // Loss of ready on a digital monitor drops the transmitter at the next edge
   chk_tx_drop: assert property (
      (st_q == ST_RUN) && dig_q && !rdy_ln.lvl |=> !tx_en
      ##0 (st_q == ST_UNPLUG || st_q == ST_OFF))
      else $error("transmitter not disabled on unplug");

   // Reattach raises the sticky status and probes again
   chk_reattach_irq: assert property (
      (st_q == ST_UNPLUG) && rdy_ln.lvl && run_en
      |=> ist_q[EVT_REATTACH] && st_q == ST_PRI_REQ)
      else $error("reattach event missing");

   // An enabled reattach event raises the line at the next edge
   chk_irq_level: assert property (
      evt[EVT_REATTACH] && ien_q[EVT_REATTACH] |=> irq)
      else $error("interrupt not raised for enabled event");

   // Status read shows the transmitter state of the setup cycle
   chk_status_tx: assert property (
      psel && !penable && !pwrite && paddr == OFS_STATUS
      |=> prdata[STAT_TX_BIT] == $past(tx_en))
      else $error("status does not report transmitter state");

   // Ready level follows the pin within four edges
   chk_sync_delay: assert property (
      $rose(rdy_pin) ##1 rdy_pin [*4] |-> rdy_ln.lvl)
      else $error("ready level not synchronised in time");

endmodule // hpds_host_seq

// file: common/hpds_pkg.sv
package hpds_pkg;

   ////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned RETRY_TIME_S = 30;
   // Whole probe retry window in cycles
   localparam int unsigned RETRY_CYCLES = RETRY_TIME_S * CLK_HZ;
   localparam int          TMR_W        = 31;

   ////////////////////////////////////////////////////////////////////
   // Serial addresses of the identification data
   localparam logic [7:0] ADDR_PRI = 8'hA2;
   localparam logic [7:0] ADDR_ALT = 8'hA0;

   ////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_STATUS  = 12'h004;
   localparam logic [11:0] OFS_INT_ST  = 12'h008;
   localparam logic [11:0] OFS_INT_EN  = 12'h00C;
   localparam logic [11:0] OFS_INT_CLR = 12'h010;

   // Control fields and reset value
   localparam int         CTRL_RUN_BIT = 0;
   localparam logic [0:0] CTRL_RST     = 1'h0;

   // Status fields
   localparam int STAT_CAP_LSB = 0;
   localparam int STAT_TX_BIT  = 3;
   localparam int STAT_RDY_BIT = 4;
   localparam int STAT_DIG_BIT = 5;

   // Interrupt event bits
   localparam int INT_W          = 4;
   localparam int EVT_REATTACH   = 0;
   localparam int EVT_UNPLUG     = 1;
   localparam int EVT_DETECTED   = 2;
   localparam int EVT_RETRY_OUT  = 3;
   localparam logic [3:0] INT_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////
   // Detected or assumed monitor capability
   typedef enum logic [2:0] {
      CAP_NONE     = 3'h0,
      CAP_VGA      = 3'h1,
      CAP_ALT_DATA = 3'h2,
      CAP_ANALOGUE = 3'h3,
      CAP_DIGITAL  = 3'h4
   } hpds_cap_t;

endpackage

// file: common/hpds_sync_if.sv
// Cleaned ready-line level and its edges
interface hpds_sync_if;
   logic raw;   // Pin level as it arrives
   logic lvl;   // Filtered level
   logic rise;  // One-cycle pulse on recovery
   logic fall;  // One-cycle pulse on loss
   modport src (input raw, output lvl, rise, fall);
   modport dst (output raw, input lvl, rise, fall);
endinterface

// file: core/hpds_sync.sv
module hpds_sync
   import hpds_pkg::*;
(
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  nrst,
   // Filtered line
   hpds_sync_if.src   ln
);

   logic s1_q;   // First stage, read only by second
   logic s2_q;   // Second stage
   logic s3_q;   // Third stage
   logic lvl_q;  // Accepted level
   logic rise_q; // Recovery pulse
   logic fall_q; // Loss pulse

   ////////////////////////////////////////////////////////////////////
   // Three-stage chain; a change counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         lvl_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         s1_q   <= ln.raw;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         // Agreement filters a single-cycle glitch
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
         rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
         fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
      end
   end

   assign ln.lvl  = lvl_q;
   assign ln.rise = rise_q;
   assign ln.fall = fall_q;

   // Edge pulses mark exactly the cycles in which the level turns
   chk_edge_pulse: assert property (
      @(posedge mclk) disable iff (!nrst)
      (rise_q == (lvl_q && !$past(lvl_q)))
      && (fall_q == (!lvl_q && $past(lvl_q))))
      else $error("ready edge pulse out of step with level");

endmodule // hpds_sync

// file: test/hpds_far_end.sv
module hpds_far_end
   import hpds_pkg::*;
(
   // Clock and reset
   input  logic       mclk,
   input  logic       nrst,
   // Probe engine
   input  logic       probe_req,
   input  logic [7:0] probe_addr,
   output logic       probe_done,
   output logic       probe_found,
   output logic       probe_digital,
   output logic       probe_link,
   // Load check
   input  logic       load_req,
   output logic       load_done,
   output logic       load_found,
   // Supply and ready line
   input  logic       cfg_supply_en,
   input  logic       tx_en,
   output logic       rdy_pin,
   // Scenario knobs
   input  logic       pri_ok,
   input  logic       alt_ok,
   input  logic       dig,
   input  logic       link,
   input  logic       load_ok,
   input  logic       mon_on,
   // Observations
   output int         a2_cnt,
   output int         alt_at
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] wait_q;  // Cycles left before the answer
   logic       busy_q;  // A job is in flight
   logic       isld_q;  // Job is a load check
   logic       alt_q;   // Job probes the alternate address
   logic       done_q;  // Answer cycle
   logic       tog_q;   // Junk, so stale answers never look valid
   int         cyc_q;   // Cycles since supply on

   ////////////////////////////////////////////////////////////////////
   // One job at a time, answered four cycles after its request
   always_ff @(posedge mclk) begin
      tog_q  <= ~tog_q;
      done_q <= 1'b0;
      if (!nrst) begin
         busy_q <= 1'b0;
         tog_q  <= 1'b0;
      end else if (busy_q) begin
         wait_q <= wait_q - 2'h1;
         if (wait_q == 2'h0) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
      end else if (probe_req || load_req) begin
         busy_q <= 1'b1;
         wait_q <= 2'h2;
         isld_q <= load_req;
         alt_q  <= (probe_addr == ADDR_ALT);
      end
   end

   // Where the probes went, and when the alternate one came
   always_ff @(posedge mclk) begin
      cyc_q <= cfg_supply_en ? cyc_q + 1 : 0;
      if (!nrst) begin
         a2_cnt <= 0;
         alt_at <= 0;
      end else if (probe_req && probe_addr == ADDR_PRI) begin
         a2_cnt <= a2_cnt + 1;
      end else if (probe_req && alt_at == 0) begin
         alt_at <= cyc_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Display side; its long timings are scaled down for simulation
   localparam int SUP_MIN  = 64;   // Supply up long enough to count
   localparam int LOSS_MIN = 4;    // Supply loss that means unplug
   localparam int QUIET    = 16;   // Pause before going quiescent
   localparam int VID_MIN  = 200;  // Video must have come by then

   logic rx_en_q;  // Video receiver enable
   logic pwr_q;    // Monitor powered up by sync detection
   logic seen_q;   // Supply was present long enough
   logic hot_q;    // Hot-plug shown to the user
   logic warn_q;   // Incompatibility warning
   int   dn_q;     // Cycles of supply loss or of hot-plug pause

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         // Quiescent, receiver off
         {rx_en_q, pwr_q, seen_q, hot_q, warn_q} <= 5'h00;
         dn_q <= 0;
      end else if (hot_q) begin
         // Receiver off, user told, then quiescent
         {rx_en_q, pwr_q, seen_q} <= 3'h0;
         dn_q  <= dn_q + 1;
         hot_q <= (dn_q < QUIET);
      end else if (cfg_supply_en) begin
         dn_q    <= 0;
         rx_en_q <= mon_on;           // Receiver follows supply
         pwr_q   <= rx_en_q & tx_en;  // Syncs ride the live link
         seen_q  <= seen_q | (cyc_q >= SUP_MIN);
         warn_q  <= warn_q | (cyc_q >= VID_MIN && !tx_en);
      end else begin
         {rx_en_q, pwr_q} <= 2'h0;
         dn_q  <= seen_q ? dn_q + 1 : 0;
         hot_q <= seen_q && dn_q >= LOSS_MIN - 1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Answer data lines carry junk outside the answer cycle; the done lines stay low
   assign probe_done    = done_q & ~isld_q;
   assign load_done     = done_q & isld_q;
   assign probe_found   = done_q ? (alt_q ? alt_ok : pri_ok) : tog_q;
   assign probe_digital = done_q ? dig : tog_q;
   assign probe_link    = done_q ? link : ~tog_q;
   assign load_found    = done_q ? load_ok : tog_q;
   // Ready only from a powered monitor on a live supply
   // A display in its hot-plug pause does not drive the line
   assign rdy_pin       = mon_on & cfg_supply_en & ~hot_q;
endmodule // hpds_far_end

// file: test/test_hpds_host_seq.sv
module test_hpds_host_seq
   import hpds_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        mclk, nrst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr, irq, cfg_supply_en, tx_en;
   logic        probe_req, probe_done, probe_found;
   logic        probe_digital, probe_link;
   logic [7:0]  probe_addr;
   logic        load_req, load_done, load_found, rdy_pin;
   logic        pri_ok, alt_ok, dig, link, load_ok, mon_on;
   int          a2_cnt, alt_at, errors, tests_run;
   // Cases: {primary, alternate, digital, link, load}
   logic [4:0]  cs [3] = '{5'h10, 5'h01, 5'h00};
   logic [31:0] ex [3] = '{32'h3, 32'h1, 32'h0};

   hpds_host_seq #(.RETRY_LIMIT(50)) i_hpds_host_seq (.*);
   hpds_far_end i_hpds_far_end (.*);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////
   task close_out;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, then an idle cycle
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         check(32'h0, 32'h1);
         close_out();
      end
      @(posedge mclk);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask

   // Settled {irq, tx_en, cfg_supply_en}
   task look(input logic [2:0] exp);
      @(negedge mclk);
      check({irq, tx_en, cfg_supply_en}, exp);
      @(posedge mclk);
   endtask

   task wait_tx(input logic v, input int lim);
      int n;
      n = 0;
      while (tx_en !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
      check(tx_en, v);
      if (tx_en !== v) close_out();
   endtask

   task poll(input logic [11:0] a, input logic [31:0] m, v);
      int n;
      n = 0;
      do begin
         acc(1'b0, a, 32'h0);
         n++;
      end while ((rdat & m) !== v && n < 200);
      check(rdat & m, v);
      if ((rdat & m) !== v) close_out();
   endtask

   ////////////////////////////////////////////////////////////////////
   // Global guard against a hang
   initial begin
      repeat (100000) @(posedge mclk);
      errors++;
      close_out();
   end

   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {pri_ok, alt_ok, dig, link, load_ok, mon_on} = '0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_INT_ST, 32'h0);
      look(3'b000);
      acc(1'b0, 12'h020, 32'h0);
      check(rerr, 1'b1);
      rd(OFS_INT_CLR, 32'h0);
      wr(OFS_INT_EN, 32'hF);
      // Digital monitor, ready line still low
      {pri_ok, dig, link} <= 3'b111;
      wr(OFS_CTRL, 32'h1);
      repeat (20) @(posedge mclk);
      look(3'b001);
      check(probe_addr, ADDR_PRI);
      mon_on <= 1'b1;
      wait_tx(1'b1, 20);
      rd(OFS_STATUS, 32'h3C);
      rd(OFS_INT_ST, 32'h4);
      look(3'b111);
      wr(OFS_INT_CLR, 32'hF);
      look(3'b011);
      // Unplug, then reattach
      mon_on <= 1'b0;
      wait_tx(1'b0, 8);
      rd(OFS_INT_ST, 32'h2);
      mon_on <= 1'b1;
      wait_tx(1'b1, 40);
      rd(OFS_INT_ST, 32'h7);
      wr(OFS_INT_EN, 32'h0);
      look(3'b011);
      wr(OFS_INT_EN, 32'h1);
      look(3'b111);
      wr(OFS_INT_CLR, 32'hF);
      look(3'b011);
      // Second reset mid-run, then the alternate address
      nrst <= 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      {pri_ok, alt_ok, dig, mon_on} <= 4'b0100;
      @(posedge mclk);
      look(3'b000);
      wr(OFS_CTRL, 32'h1);
      wait_tx(1'b1, 300);
      check(a2_cnt > 1, 1'b1);
      check(alt_at >= 50, 1'b1);
      rd(OFS_STATUS, 32'h0A);
      rd(OFS_INT_ST, 32'h8 | 32'h4);
      // Primary analogue, then load found, then nothing
      for (int k = 0; k < 3; k++) begin
         wr(OFS_CTRL, 32'h0);
         look(3'b000);
         wr(OFS_INT_CLR, 32'hF);
         {pri_ok, alt_ok, dig, link, load_ok} <= cs[k];
         wr(OFS_CTRL, 32'h1);
         poll(OFS_INT_ST, 32'h4, 32'h4);
         rd(OFS_STATUS, ex[k]);
      end
      close_out();
   end
endmodule // test_hpds_host_seq
